// *** rtl/rcs_pkg.sv ***
// Purpose: Shared constants and types for the reset cause and start-up logic
// Assumes: One clock, the oscillator clock, at 20 MHz
// Notes:   Register offsets are Wishbone byte addresses
package rcs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Power-up timer period in ms, and its cycle count at the clock rate
  localparam int unsigned PUP_TIME_MS   = 72;
  localparam int unsigned PUP_CYCLES    = (PUP_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // Oscillator start-up period in oscillator periods; the clock is the oscillator
  localparam int unsigned OST_TOSC      = 1024;
  localparam int unsigned OST_CYCLES    = OST_TOSC;
  localparam int          TMR_W         = 21;

  localparam int          PC_W          = 13;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC    = 13'h0004;

  localparam logic [4:0]  ADR_CAUSE     = 5'h00;
  localparam logic [4:0]  ADR_STATUS    = 5'h04;
  localparam logic [4:0]  ADR_CONFIG    = 5'h08;
  localparam logic [4:0]  ADR_STATE     = 5'h0C;

  localparam int          CAUSE_BROWNOUT_BIT = 0;
  localparam int          CAUSE_POWERON_BIT  = 1;
  localparam int          STAT_EXPIRY_BIT    = 4;
  localparam int          STAT_SLEEP_BIT     = 3;
  localparam int          CFG_OSC_LSB        = 0;
  localparam int          CFG_PUP_EN_N_BIT   = 2;
  localparam int          CFG_BROWNOUT_EN    = 3;
  localparam int          ST_HOLD_BIT        = 2;
  localparam int          ST_CAUSE_LSB       = 4;

  localparam logic        BROWNOUT_FLAG_RST  = 1'b1;
  localparam logic [3:0]  CFG_RST            = 4'hD;

  typedef enum logic [1:0] {
    RCS_OSC_SLOW   = 2'b00,
    RCS_OSC_XTAL   = 2'b01,
    RCS_OSC_FAST   = 2'b10,
    RCS_OSC_RESCAP = 2'b11
  } rcs_osc_t;

  typedef enum logic [1:0] {
    RCS_ST_RUN   = 2'b00,
    RCS_ST_SLEEP = 2'b01,
    RCS_ST_HOLD  = 2'b10
  } rcs_state_t;

  typedef enum logic [1:0] {
    RCS_TGT_ZERO = 2'b00,
    RCS_TGT_NEXT = 2'b01,
    RCS_TGT_VEC  = 2'b10
  } rcs_tgt_t;

  typedef enum logic [2:0] {
    RCS_CAUSE_POWERON  = 3'b000,
    RCS_CAUSE_BROWNOUT = 3'b001,
    RCS_CAUSE_WDT      = 3'b010,
    RCS_CAUSE_MCLEAR   = 3'b011,
    RCS_CAUSE_WDT_WAKE = 3'b100,
    RCS_CAUSE_IRQ_WAKE = 3'b101
  } rcs_cause_t;
endpackage

// *** rtl/rcs_startup_timer.sv ***
// Purpose: Down counter that times the start-up delay
// Assumes: start reloads the count; busy covers the start cycle too
// Notes:   A load of zero gives busy for the start cycle only
`timescale 1ns/1ps
module rcs_startup_timer #(
  parameter int W = 21
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = start ? load : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign busy    = start | (cnt_r != '0);

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// *** rtl/rcs_reset_cause.sv ***
// Purpose: Reset cause flags, processor status flags and start-up delay control
// Assumes: RESET is the power-on reset; event inputs are synchronous levels
// Notes:   Registers sit on a classic Wishbone slave with one wait state
`timescale 1ns/1ps
// Functional notes
// - Brown-out flag bit 0, power-on flag bit 1
// - Software sets brown-out flag after power-on
// - Brown-out reset clears the brown-out flag
// - Brown-out flag meaningless while detection disabled
// - Power-on flag cleared by power-on or by a software write of 0
// - Delay per oscillator mode and reset cause
// - Power-on sets expiry and sleep flags
// - Flag pairs encode brown-out and watchdog causes
// - Master clear flag effects in run, sleep
// - Resets load 000h; wakes resume next instruction
// - Interrupt wake with enable loads vector
module rcs_reset_cause #(
  parameter int unsigned PUP_CYC = rcs_pkg::PUP_CYCLES,
  parameter int          TMR_W   = rcs_pkg::TMR_W
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET,
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [4:0]               WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output logic      [31:0]              WB_DAT_O,
  output logic                          WB_ACK_O,
  output logic                          WB_ERR_O,
  input  wire logic                     BROWNOUT_DET,
  input  wire logic                     MASTER_CLEAR_PIN_N,
  input  wire logic                     WDT_TIMEOUT,
  input  wire logic                     WAKE_IRQ,
  input  wire logic                     SLEEP_ENTER,
  input  wire logic                     WDT_CLEAR,
  input  wire logic                     GLOBAL_IRQ_ENABLE,
  input  wire logic [rcs_pkg::PC_W-1:0] PC_NEXT,
  output logic                          CPU_RESET_HOLD,
  output logic                          PC_LOAD,
  output logic      [rcs_pkg::PC_W-1:0] PC_LOAD_VALUE,
  output logic                          WATCHDOG_EXPIRY_FLAG_N,
  output logic                          SLEEP_ENTRY_FLAG_N
);
  localparam logic [TMR_W-1:0] PUP_C = TMR_W'(PUP_CYC);
  localparam logic [TMR_W-1:0] OST_C = TMR_W'(rcs_pkg::OST_CYCLES);

  rcs_pkg::rcs_state_t state_r;
  rcs_pkg::rcs_state_t state_nxt;
  rcs_pkg::rcs_tgt_t   tgt_r;
  rcs_pkg::rcs_tgt_t   tgt_nxt;
  rcs_pkg::rcs_cause_t cause_r;
  rcs_pkg::rcs_cause_t cause_nxt;

  logic                     brownout_flag_n_r;
  logic                     brownout_flag_n_nxt;
  logic                     poweron_flag_n_r;
  logic                     poweron_flag_n_nxt;
  logic                     expiry_r;
  logic                     expiry_nxt;
  logic                     sleep_flag_r;
  logic                     sleep_flag_nxt;
  logic [3:0]               cfg_r;
  logic                     pup_pend_r;
  logic                     ack_r;
  logic                     err_r;
  logic [31:0]              dat_r;
  logic [31:0]              rd_data;
  logic [rcs_pkg::PC_W-1:0] wake_pc_r;
  logic                     pc_load_r;
  logic [rcs_pkg::PC_W-1:0] pc_val_r;
  logic [rcs_pkg::PC_W-1:0] pc_val_nxt;
  logic [TMR_W-1:0]         tmr_load;
  logic                     tmr_busy;

  // Bus decode
  wire bus_req   = WB_CYC_I & WB_STB_I;
  wire mapped    = ~WB_ADR_I[4];
  wire bus_first = bus_req & ~ack_r & ~err_r;
  wire bus_wr    = bus_req & WB_WE_I & ack_r & WB_SEL_I[0];
  wire wr_cause  = bus_wr & (WB_ADR_I == rcs_pkg::ADR_CAUSE);
  wire wr_config = bus_wr & (WB_ADR_I == rcs_pkg::ADR_CONFIG);

  // Configuration fields
  wire [1:0] osc_mode     = cfg_r[rcs_pkg::CFG_OSC_LSB +: 2];
  wire       xtal         = osc_mode != rcs_pkg::RCS_OSC_RESCAP;
  wire       pup_timer_n  = cfg_r[rcs_pkg::CFG_PUP_EN_N_BIT];
  wire       brownout_en  = cfg_r[rcs_pkg::CFG_BROWNOUT_EN];

  // Event decode, highest priority first
  wire in_run      = state_r == rcs_pkg::RCS_ST_RUN;
  wire in_sleep    = state_r == rcs_pkg::RCS_ST_SLEEP;
  wire in_hold     = state_r == rcs_pkg::RCS_ST_HOLD;
  wire ev_bor      = BROWNOUT_DET & brownout_en;
  wire ev_master_clear_pin     = ~MASTER_CLEAR_PIN_N & ~ev_bor;
  wire quiet       = ~ev_bor & ~ev_master_clear_pin;
  wire ev_wdt_rst  = quiet & in_run & WDT_TIMEOUT;
  wire ev_wdt_wake = quiet & in_sleep & WDT_TIMEOUT;
  wire ev_irq_wake = quiet & in_sleep & WAKE_IRQ & ~WDT_TIMEOUT;
  wire ev_sleep    = quiet & in_run & SLEEP_ENTER & ~WDT_TIMEOUT;
  wire ev_clrwdt   = quiet & in_run & WDT_CLEAR & ~SLEEP_ENTER & ~WDT_TIMEOUT;
  wire ev_wake     = ev_wdt_wake | ev_irq_wake;
  wire tmr_start   = pup_pend_r | ev_bor | ev_master_clear_pin | ev_wdt_rst | ev_wake;
  wire hold_done   = in_hold & ~tmr_busy;

  rcs_startup_timer #(
    .W     (TMR_W)
  ) u_timer (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .start (tmr_start),
    .load  (tmr_load),
    .busy  (tmr_busy)
  );

  // Delay for the cause being started
  always_comb
  begin
    tmr_load = '0;
    if (ev_bor)
      tmr_load = xtal ? PUP_C + OST_C : PUP_C;
    else if (pup_pend_r)
      tmr_load = xtal ? (pup_timer_n ? OST_C : PUP_C + OST_C)
                      : (pup_timer_n ? '0 : PUP_C);
    else if (ev_wake)
      tmr_load = xtal ? OST_C : '0;
  end

  // Sequencing of run, sleep and reset hold
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rcs_pkg::RCS_ST_RUN:
        if (tmr_start)
          state_nxt = rcs_pkg::RCS_ST_HOLD;
        else if (ev_sleep)
          state_nxt = rcs_pkg::RCS_ST_SLEEP;
      rcs_pkg::RCS_ST_SLEEP:
        if (tmr_start)
          state_nxt = rcs_pkg::RCS_ST_HOLD;
      rcs_pkg::RCS_ST_HOLD:
        if (hold_done)
          state_nxt = rcs_pkg::RCS_ST_RUN;
      default:
        state_nxt = rcs_pkg::RCS_ST_HOLD;
    endcase
  end

  // Resume point and cause record
  always_comb
  begin
    tgt_nxt   = tgt_r;
    cause_nxt = cause_r;
    if (ev_bor)
    begin
      tgt_nxt   = rcs_pkg::RCS_TGT_ZERO;
      cause_nxt = rcs_pkg::RCS_CAUSE_BROWNOUT;
    end
    else if (pup_pend_r)
    begin
      tgt_nxt   = rcs_pkg::RCS_TGT_ZERO;
      cause_nxt = rcs_pkg::RCS_CAUSE_POWERON;
    end
    else if (ev_master_clear_pin | ev_wdt_rst)
    begin
      tgt_nxt   = rcs_pkg::RCS_TGT_ZERO;
      cause_nxt = ev_master_clear_pin ? rcs_pkg::RCS_CAUSE_MCLEAR : rcs_pkg::RCS_CAUSE_WDT;
    end
    else if (ev_wdt_wake)
    begin
      tgt_nxt   = rcs_pkg::RCS_TGT_NEXT;
      cause_nxt = rcs_pkg::RCS_CAUSE_WDT_WAKE;
    end
    else if (ev_irq_wake)
    begin
      tgt_nxt   = GLOBAL_IRQ_ENABLE ? rcs_pkg::RCS_TGT_VEC : rcs_pkg::RCS_TGT_NEXT;
      cause_nxt = rcs_pkg::RCS_CAUSE_IRQ_WAKE;
    end
  end

  always_comb
  begin
    case (tgt_r)
      rcs_pkg::RCS_TGT_NEXT: pc_val_nxt = wake_pc_r;
      rcs_pkg::RCS_TGT_VEC:  pc_val_nxt = rcs_pkg::PC_IRQ_VEC;
      default:               pc_val_nxt = rcs_pkg::PC_RESET;
    endcase
  end

  // Processor status flags, active low
  always_comb
  begin
    expiry_nxt     = expiry_r;
    sleep_flag_nxt = sleep_flag_r;
    if (ev_bor)
    begin
      expiry_nxt     = 1'b1;
      sleep_flag_nxt = 1'b1;
    end
    else if (ev_master_clear_pin)
    begin
      if (in_sleep)
      begin
        expiry_nxt     = 1'b1;
        sleep_flag_nxt = 1'b0;
      end
    end
    else if (ev_wdt_rst | ev_wdt_wake)
    begin
      expiry_nxt     = 1'b0;
      sleep_flag_nxt = ev_wdt_rst;
    end
    else if (ev_irq_wake | ev_sleep)
    begin
      expiry_nxt     = 1'b1;
      sleep_flag_nxt = 1'b0;
    end
    else if (ev_clrwdt)
    begin
      expiry_nxt     = 1'b1;
      sleep_flag_nxt = 1'b1;
    end
  end

  // Reset cause flags: hardware clear wins over a software write
  always_comb
  begin
    brownout_flag_n_nxt = brownout_flag_n_r;
    poweron_flag_n_nxt  = poweron_flag_n_r;
    if (wr_cause)
    begin
      brownout_flag_n_nxt = WB_DAT_I[rcs_pkg::CAUSE_BROWNOUT_BIT];
      poweron_flag_n_nxt  = WB_DAT_I[rcs_pkg::CAUSE_POWERON_BIT];
    end
    if (ev_bor)
      brownout_flag_n_nxt = 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      state_r           <= rcs_pkg::RCS_ST_HOLD;
      tgt_r             <= rcs_pkg::RCS_TGT_ZERO;
      cause_r           <= rcs_pkg::RCS_CAUSE_POWERON;
      pup_pend_r        <= 1'b1;
      brownout_flag_n_r <= rcs_pkg::BROWNOUT_FLAG_RST;
      poweron_flag_n_r  <= 1'b0;
      expiry_r          <= 1'b1;
      sleep_flag_r      <= 1'b1;
      cfg_r             <= rcs_pkg::CFG_RST;
    end
    else
    begin
      state_r           <= state_nxt;
      tgt_r             <= tgt_nxt;
      cause_r           <= cause_nxt;
      pup_pend_r        <= pup_pend_r & ~MASTER_CLEAR_PIN_N;
      brownout_flag_n_r <= brownout_flag_n_nxt;
      poweron_flag_n_r  <= poweron_flag_n_nxt;
      expiry_r          <= expiry_nxt;
      sleep_flag_r      <= sleep_flag_nxt;
      if (wr_config)
        cfg_r <= WB_DAT_I[3:0];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      wake_pc_r <= rcs_pkg::PC_RESET;
      pc_load_r <= 1'b0;
      pc_val_r  <= rcs_pkg::PC_RESET;
    end
    else
    begin
      if (ev_wake)
        wake_pc_r <= PC_NEXT;
      pc_load_r <= hold_done;
      if (hold_done)
        pc_val_r <= pc_val_nxt;
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = '0;
    case (WB_ADR_I)
      rcs_pkg::ADR_CAUSE:
      begin
        rd_data[rcs_pkg::CAUSE_BROWNOUT_BIT] = brownout_flag_n_r;
        rd_data[rcs_pkg::CAUSE_POWERON_BIT]  = poweron_flag_n_r;
      end
      rcs_pkg::ADR_STATUS:
      begin
        rd_data[rcs_pkg::STAT_EXPIRY_BIT] = expiry_r;
        rd_data[rcs_pkg::STAT_SLEEP_BIT]  = sleep_flag_r;
      end
      rcs_pkg::ADR_CONFIG:
        rd_data[3:0] = cfg_r;
      rcs_pkg::ADR_STATE:
      begin
        rd_data[1:0]                     = state_r;
        rd_data[rcs_pkg::ST_HOLD_BIT]    = in_hold;
        rd_data[rcs_pkg::ST_CAUSE_LSB +: 3] = cause_r;
      end
      default:
        rd_data = '0;
    endcase
  end

  // Wishbone answer one cycle after the request; writes land on the ack edge
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= '0;
    end
    else
    begin
      ack_r <= bus_first & mapped;
      err_r <= bus_first & ~mapped;
      if (bus_first)
        dat_r <= rd_data;
    end
  end

  assign WB_ACK_O               = ack_r;
  assign WB_ERR_O               = err_r;
  assign WB_DAT_O               = dat_r;
  assign CPU_RESET_HOLD         = in_hold;
  assign PC_LOAD                = pc_load_r;
  assign PC_LOAD_VALUE          = pc_val_r;
  assign WATCHDOG_EXPIRY_FLAG_N = expiry_r;
  assign SLEEP_ENTRY_FLAG_N     = sleep_flag_r;

  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  property p_pup_flags;
    $past(RESET) |-> !poweron_flag_n_r && expiry_r && sleep_flag_r;
  endproperty
  a_pup_flags: assert property (p_pup_flags) else $error("power-on flags wrong");

  property p_poweron_kept;
    !wr_cause |=> $stable(poweron_flag_n_r);
  endproperty
  a_poweron_kept: assert property (p_poweron_kept) else $error("power-on flag moved");

  property p_brownout_clr;
    ev_bor |=> !brownout_flag_n_r && expiry_r && sleep_flag_r;
  endproperty
  a_brownout_clr: assert property (p_brownout_clr) else $error("brown-out not recorded");

  property p_sw_set;
    wr_cause && WB_DAT_I[0] && !ev_bor |=> brownout_flag_n_r;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("brown-out flag not set");

  property p_wdt_codes;
    (ev_wdt_rst || ev_wdt_wake) |=> !expiry_r && (sleep_flag_r == $past(in_run));
  endproperty
  a_wdt_codes: assert property (p_wdt_codes) else $error("watchdog code wrong");

  property p_master_clear_pin_run;
    ev_master_clear_pin && !in_sleep |=> $stable(expiry_r) && $stable(sleep_flag_r);
  endproperty
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("master clear moved flags");

  property p_sleep_wake;
    (ev_irq_wake || (ev_master_clear_pin && in_sleep)) |=> expiry_r && !sleep_flag_r;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake flags wrong");

  property p_pc_value;
    PC_LOAD |-> (tgt_r == rcs_pkg::RCS_TGT_ZERO) == (PC_LOAD_VALUE == rcs_pkg::PC_RESET)
             || tgt_r == rcs_pkg::RCS_TGT_NEXT;
  endproperty
  a_pc_value: assert property (p_pc_value) else $error("resume address wrong");

  property p_vector;
    ev_irq_wake && GLOBAL_IRQ_ENABLE |=> tgt_r == rcs_pkg::RCS_TGT_VEC;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not selected");

  property p_wake_delay;
    ev_wake && !ev_bor && xtal |-> tmr_load == OST_C;
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");

  sequence s_ost_start;
    tmr_start && tmr_load == OST_C;
  endsequence
  property p_hold;
    s_ost_start |=> CPU_RESET_HOLD [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("released too early");
endmodule

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the reset cause and start-up delay block
// Assumes: Power-up delay shortened to 50 cycles; oscillator start-up stays 1024
// Notes:   Hold length is counted in cycles from the edge that takes an event
`timescale 1ns/1ps
module testbench;
  localparam int PUP = 50;
  localparam int OST = rcs_pkg::OST_CYCLES;
  logic        SYS_CLK            = 1'b0;
  logic        RESET              = 1'b1;
  logic        WB_CYC_I           = 1'b0;
  logic        WB_STB_I           = 1'b0;
  logic        WB_WE_I            = 1'b0;
  logic [4:0]  WB_ADR_I           = 5'h00;
  logic [3:0]  WB_SEL_I           = 4'hF;
  logic [31:0] WB_DAT_I           = 32'h0;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O;
  logic        WB_ERR_O;
  logic        BROWNOUT_DET       = 1'b0;
  logic        MASTER_CLEAR_PIN_N = 1'b1;
  logic        WDT_TIMEOUT        = 1'b0;
  logic        WAKE_IRQ           = 1'b0;
  logic        SLEEP_ENTER        = 1'b0;
  logic        WDT_CLEAR          = 1'b0;
  logic        GLOBAL_IRQ_ENABLE  = 1'b0;
  logic [12:0] PC_NEXT            = 13'h0000;
  logic        CPU_RESET_HOLD;
  logic        PC_LOAD;
  logic [12:0] PC_LOAD_VALUE;
  logic        WATCHDOG_EXPIRY_FLAG_N;
  logic        SLEEP_ENTRY_FLAG_N;
  int          num_errors         = 0;
  int          checked            = 0;

  always #25 SYS_CLK = ~SYS_CLK;

  rcs_reset_cause #(.PUP_CYC(PUP), .TMR_W(rcs_pkg::TMR_W)) i_rcs_reset_cause (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .BROWNOUT_DET(BROWNOUT_DET),
    .MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .WDT_TIMEOUT(WDT_TIMEOUT), .WAKE_IRQ(WAKE_IRQ),
    .SLEEP_ENTER(SLEEP_ENTER), .WDT_CLEAR(WDT_CLEAR), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .PC_NEXT(PC_NEXT), .CPU_RESET_HOLD(CPU_RESET_HOLD), .PC_LOAD(PC_LOAD),
    .PC_LOAD_VALUE(PC_LOAD_VALUE), .WATCHDOG_EXPIRY_FLAG_N(WATCHDOG_EXPIRY_FLAG_N),
    .SLEEP_ENTRY_FLAG_N(SLEEP_ENTRY_FLAG_N));

  task automatic expect_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single Wishbone cycle, held until ack or err is sampled
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd,
                    input logic [3:0] sel, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= wd;
    WB_SEL_I <= sel;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && n < 50);
    rd = WB_DAT_O;
    er = WB_ERR_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    expect_val(n < 50, 1'b1, "bus answer in time");
    if (n >= 50)
      tally_and_finish();
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        er;
    wb(1'b1, adr, d, 4'hF, rd, er);
    expect_val(er, exp_err, "write error response");
  endtask

  task automatic rdchk(input logic [4:0] adr, input logic [31:0] mask, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        er;
    wb(1'b0, adr, 32'h0, 4'hF, rd, er);
    expect_val(er, 1'b0, "read error response");
    expect_val(rd & mask, exp, what);
  endtask

  // Bits: 0 brown-out, 1 master clear, 2 watchdog, 3 wake, 4 sleep, 5 clear watchdog
  task automatic fire(input logic [5:0] ev);
    @(posedge SYS_CLK);
    BROWNOUT_DET       <= ev[0];
    MASTER_CLEAR_PIN_N <= ~ev[1];
    WDT_TIMEOUT        <= ev[2];
    WAKE_IRQ           <= ev[3];
    SLEEP_ENTER        <= ev[4];
    WDT_CLEAR          <= ev[5];
    @(posedge SYS_CLK);
    BROWNOUT_DET       <= 1'b0;
    MASTER_CLEAR_PIN_N <= 1'b1;
    WDT_TIMEOUT        <= 1'b0;
    WAKE_IRQ           <= 1'b0;
    SLEEP_ENTER        <= 1'b0;
    WDT_CLEAR          <= 1'b0;
    #1;
  endtask

  // Counts held cycles after the taking edge, then checks the restart point
  task automatic await_run(input int dly, input logic [12:0] pc);
    int n;
    n = 0;
    while (CPU_RESET_HOLD === 1'b1 && n < 3000)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    expect_val(n, dly + 1, "held cycles");
    if (n >= 3000)
      tally_and_finish();
    expect_val(PC_LOAD, 1'b1, "restart strobe");
    expect_val(PC_LOAD_VALUE, pc, "restart address");
  endtask

  task automatic chk_flags(input logic to, input logic pd);
    expect_val(WATCHDOG_EXPIRY_FLAG_N, to, "expiry flag port");
    expect_val(SLEEP_ENTRY_FLAG_N, pd, "sleep flag port");
    rdchk(rcs_pkg::ADR_STATUS, 32'hFFFF_FFFF, {27'h0, to, pd, 3'h0}, "status register");
  endtask

  task automatic power_on();
    logic [31:0] rd;
    logic        er;
    @(posedge SYS_CLK);
    RESET <= 1'b1;
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    await_run(OST, 13'h0000);
    chk_flags(1'b1, 1'b1);
    rdchk(rcs_pkg::ADR_CAUSE, 32'h0000_0002, 32'h0, "power-on flag cleared");
    rdchk(rcs_pkg::ADR_CONFIG, 32'h0000_000F, {28'h0, rcs_pkg::CFG_RST}, "config reset");
    wr(rcs_pkg::ADR_CAUSE, 32'h3, 1'b0);
    rdchk(rcs_pkg::ADR_CAUSE, 32'hFFFF_FFFF, 32'h3, "cause after set");
    // Write with lane 0 disabled must leave both cause flags alone
    wb(1'b1, rcs_pkg::ADR_CAUSE, 32'h0, 4'hE, rd, er);
    expect_val(er, 1'b0, "masked write response");
    rdchk(rcs_pkg::ADR_CAUSE, 32'hFFFF_FFFF, 32'h3, "cause after masked write");
    wr(rcs_pkg::ADR_STATUS, 32'h0, 1'b0);
    chk_flags(1'b1, 1'b1);
    wr(5'h14, 32'h0, 1'b1);
  endtask

  task automatic brownout_reset(input logic [3:0] cfg, input int dly);
    wr(rcs_pkg::ADR_CONFIG, {28'h0, cfg}, 1'b0);
    fire(6'h01);
    await_run(dly, 13'h0000);
    rdchk(rcs_pkg::ADR_CAUSE, 32'hFFFF_FFFF, 32'h2, "cause after brown-out");
    chk_flags(1'b1, 1'b1);
    rdchk(rcs_pkg::ADR_STATE, 32'h0000_0077, 32'h10, "state after brown-out");
    wr(rcs_pkg::ADR_CAUSE, 32'h3, 1'b0);
  endtask

  task automatic wdt_and_master_clear_pin();
    wr(rcs_pkg::ADR_CONFIG, 32'hD, 1'b0);
    fire(6'h04);
    await_run(0, 13'h0000);
    chk_flags(1'b0, 1'b1);
    rdchk(rcs_pkg::ADR_CAUSE, 32'hFFFF_FFFF, 32'h3, "cause after watchdog");
    fire(6'h02);
    await_run(0, 13'h0000);
    chk_flags(1'b0, 1'b1);
    fire(6'h10);
    fire(6'h02);
    await_run(0, 13'h0000);
    chk_flags(1'b1, 1'b0);
  endtask

  task automatic wdt_wake();
    fire(6'h20);
    chk_flags(1'b1, 1'b1);
    fire(6'h10);
    @(posedge SYS_CLK);
    PC_NEXT <= 13'h1123;
    fire(6'h04);
    await_run(OST, 13'h1123);
    chk_flags(1'b0, 1'b0);
  endtask

  task automatic irq_wake(input logic global_irq_enable, input int dly, input logic [12:0] pc);
    fire(6'h10);
    @(posedge SYS_CLK);
    GLOBAL_IRQ_ENABLE <= global_irq_enable;
    PC_NEXT           <= 13'h0ABC;
    fire(6'h08);
    await_run(dly, pc);
    chk_flags(1'b1, 1'b0);
    rdchk(rcs_pkg::ADR_STATE, 32'h0000_0077, 32'h50, "state after wake");
    GLOBAL_IRQ_ENABLE <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    power_on();
    brownout_reset(4'h9, PUP + OST);
    brownout_reset(4'hB, PUP);
    brownout_reset(4'h8, PUP + OST);
    brownout_reset(4'hA, PUP + OST);
    wdt_and_master_clear_pin();
    wdt_wake();
    irq_wake(1'b1, OST, rcs_pkg::PC_IRQ_VEC);
    irq_wake(1'b0, OST, 13'h0ABC);
    wr(rcs_pkg::ADR_CONFIG, 32'hB, 1'b0);
    irq_wake(1'b0, 0, 13'h0ABC);
    power_on();
    tally_and_finish();
  end
endmodule
